// ---- core/dar_consts.vh ----
`ifndef DAR_CONSTS_VH
`define DAR_CONSTS_VH

// ----------------------------------------
// Result and stream shape
// ----------------------------------------
`define DAR_RES_W 16
`define DAR_RES_MSB 15
`define DAR_BITCNT_W 5
`define DAR_BITS_LAST 5'h0f
`define DAR_BITS_NONE 5'h00
`define DAR_WORD_W 32
`define DAR_FIFO_DEPTH 8
`define DAR_FIFO_AW 3
`define DAR_FIFO_CW 4

// ----------------------------------------
// Pin synchroniser lanes
// ----------------------------------------
`define DAR_SYNC_N 5
`define DAR_SYNC_STAGES 3
`define DAR_SY_STROBE 0
`define DAR_SY_SCK_P 1
`define DAR_SY_SCK_N 2
`define DAR_SY_LVDS 3
`define DAR_SY_CKN_TIE 4

// ----------------------------------------
// Power states and strobe sequence counts
// ----------------------------------------
`define DAR_PWR_W 2
`define DAR_PWR_OP 2'h0
`define DAR_PWR_NAP 2'h1
`define DAR_PWR_SLEEP 2'h2
`define DAR_SEQ_W 3
`define DAR_SEQ_ZERO 3'h0
`define DAR_SEQ_ONE 3'h1
`define DAR_SEQ_NAP 3'h2
`define DAR_SEQ_SLEEP 3'h4
`define DAR_SEQ_WAKE 3'h5

`endif

// ---- core/dar_fifo.v ----
`timescale 1ns/10ps
`default_nettype none

module dar_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3,
  parameter CW = 4
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // Fill side
  input wire in_valid_in,
  input wire [WIDTH-1:0] in_data_in,
  output reg in_ready_out,
  // Drain side
  output reg out_valid_out,
  output wire [WIDTH-1:0] out_data_out,
  input wire out_ready_in
);

  localparam [CW-1:0] FULL_CNT = DEPTH[CW-1:0];
  localparam [CW-1:0] ONE_CNT = {{(CW-1){1'b0}}, 1'b1};

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [CW-1:0] count_q;
  reg [CW-1:0] count_d;
  wire push;
  wire pop;

  assign push = in_valid_in && in_ready_out;
  assign pop = out_ready_in && out_valid_out;
  assign out_data_out = mem[rd_ptr_q];

  always @* begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + ONE_CNT;
    end else if (pop && !push) begin
      count_d = count_q - ONE_CNT;
    end
  end

  always @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data_in;
    end
  end

  // Flags registered so the ready and valid outputs stay flop-driven
  always @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {CW{1'b0}};
      in_ready_out <= 1'b0;
      out_valid_out <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      count_q <= count_d;
      in_ready_out <= (count_d != FULL_CNT);
      out_valid_out <= (count_d != {CW{1'b0}});
    end
  end

endmodule // dar_fifo

`default_nettype wire

// ---- core/dar_readout.v ----
// Summary of operation
// - Strobe rise starts tracking the input if the next power state is full power
// - Strobe fall holds; starts conversion only if the result buffer is not full
// - Serial clock fall shifts next bit, MSB first
// - Echo clock skew-matched to data outputs
// - Tied negative echo pin disables positive, single-ended only
// - Two strobes, static clock: enter nap
// - Clock rise leaves nap to full power
// - Two more strobes in nap: sleep
// - Single-ended: clock rise wakes from sleep
// - Fifth strobe wakes from sleep, both modes
// - Clock edges after wake restart sequence
// - Repeated strobes cycle power states forever
// - Static pin selects single-ended or differential
// - Single-ended: negative pins held low
// - Differential: pairs driven and received
`timescale 1ns/10ps
`default_nettype none
`include "dar_consts.vh"

module dar_readout (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // Host pins
  input wire convert_strobe_in,
  input wire sck_p_in,
  input wire sck_n_in,
  input wire lvds_select_in,
  input wire echo_neg_tied_in,
  // Serial outputs
  output reg channel_one_serial_out_p_out,
  output reg channel_one_serial_out_n_out,
  output reg channel_two_serial_out_p_out,
  output reg channel_two_serial_out_n_out,
  output reg echoed_shift_clock_p_out,
  output reg echoed_shift_clock_n_out,
  output reg neg_pins_oe_out,
  output reg echo_pos_oe_out,
  // Converter core side
  output reg sample_track_out,
  output reg conv_start_out,
  output reg [`DAR_PWR_W-1:0] power_state_out,
  input wire result_valid_in,
  input wire [`DAR_RES_W-1:0] result_one_in,
  input wire [`DAR_RES_W-1:0] result_two_in,
  output wire result_ready_out
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire [`DAR_SYNC_N-1:0] pins_raw;
  reg [`DAR_SYNC_N-1:0] pins_q;
  reg [`DAR_SYNC_N-1:0] pins_prev_q;
  wire [`DAR_SYNC_N-1:0] pin_rise;
  wire [`DAR_SYNC_N-1:0] pin_fall;

  assign pins_raw = {echo_neg_tied_in, lvds_select_in, sck_n_in, sck_p_in, convert_strobe_in};

  genvar gi;
  generate
    for (gi = 0; gi < `DAR_SYNC_N; gi = gi + 1) begin : g_sync
      reg [`DAR_SYNC_STAGES-1:0] sy_q;
      // First stage feeds only the second; level moves once 2nd and 3rd agree
      always @(posedge clk_in) begin
        if (rst_in) begin
          sy_q <= {`DAR_SYNC_STAGES{1'b0}};
          pins_q[gi] <= 1'b0;
          pins_prev_q[gi] <= 1'b0;
        end else begin
          sy_q <= {sy_q[`DAR_SYNC_STAGES-2:0], pins_raw[gi]};
          if (sy_q[1] == sy_q[2]) begin
            pins_q[gi] <= sy_q[2];
          end
          pins_prev_q[gi] <= pins_q[gi];
        end
      end
    end
  endgenerate

  assign pin_rise = pins_q & ~pins_prev_q;
  assign pin_fall = ~pins_q & pins_prev_q;

  // ----------------------------------------
  // Interface mode and serial clock receive
  // ----------------------------------------
  wire lvds_mode;
  wire echo_pos_off;
  reg sck_lvl_q;
  wire sck_lvl_d;
  wire sck_rise;
  wire sck_fall;
  wire strobe_rise;
  wire strobe_fall;

  assign lvds_mode = pins_q[`DAR_SY_LVDS];
  // Tie only meaningful when the negative echo pin is not driven
  assign echo_pos_off = pins_q[`DAR_SY_CKN_TIE] && !lvds_mode;
  // Differential receive uses the pair, single-ended the positive pin only
  assign sck_lvl_d = lvds_mode ? (pins_q[`DAR_SY_SCK_P] && !pins_q[`DAR_SY_SCK_N])
                               : pins_q[`DAR_SY_SCK_P];
  assign sck_rise = sck_lvl_d && !sck_lvl_q;
  assign sck_fall = !sck_lvl_d && sck_lvl_q;
  assign strobe_rise = pin_rise[`DAR_SY_STROBE];
  assign strobe_fall = pin_fall[`DAR_SY_STROBE];

  always @(posedge clk_in) begin
    if (rst_in) begin
      sck_lvl_q <= 1'b0;
    end else begin
      sck_lvl_q <= sck_lvl_d;
    end
  end

  // ----------------------------------------
  // Power mode sequencing
  // ----------------------------------------
  reg [`DAR_PWR_W-1:0] pwr_q;
  reg [`DAR_PWR_W-1:0] pwr_d;
  reg [`DAR_SEQ_W-1:0] seq_q;
  reg [`DAR_SEQ_W-1:0] seq_d;
  reg [`DAR_SEQ_W-1:0] seq_next;

  always @* begin
    pwr_d = pwr_q;
    seq_d = seq_q;
    seq_next = seq_q + `DAR_SEQ_ONE;
    case (pwr_q)
      `DAR_PWR_OP: begin
        if (sck_rise) begin
          seq_d = `DAR_SEQ_ZERO;
        end else if (strobe_rise) begin
          seq_d = seq_next;
          if (seq_next == `DAR_SEQ_NAP) begin
            pwr_d = `DAR_PWR_NAP;
          end
        end
      end
      `DAR_PWR_NAP: begin
        if (sck_rise) begin
          pwr_d = `DAR_PWR_OP;
          seq_d = `DAR_SEQ_ZERO;
        end else if (strobe_rise) begin
          seq_d = seq_next;
          if (seq_next == `DAR_SEQ_SLEEP) begin
            pwr_d = `DAR_PWR_SLEEP;
          end
        end
      end
      `DAR_PWR_SLEEP: begin
        // Differential receiver ignores the clock while asleep
        if (sck_rise && !lvds_mode) begin
          pwr_d = `DAR_PWR_OP;
          seq_d = `DAR_SEQ_ZERO;
        end else if (strobe_rise) begin
          seq_d = seq_next;
          if (seq_next == `DAR_SEQ_WAKE) begin
            pwr_d = `DAR_PWR_OP;
            // Waking pulse counts as the first of a new round
            seq_d = `DAR_SEQ_ONE;
          end
        end
      end
      default: begin
        pwr_d = `DAR_PWR_OP;
        seq_d = `DAR_SEQ_ZERO;
      end
    endcase
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      pwr_q <= `DAR_PWR_OP;
      seq_q <= `DAR_SEQ_ZERO;
      power_state_out <= `DAR_PWR_OP;
    end else begin
      pwr_q <= pwr_d;
      seq_q <= seq_d;
      power_state_out <= pwr_d;
    end
  end

  // ----------------------------------------
  // Conversion control
  // ----------------------------------------
  // No conversion is started while the result buffer is full
  wire fifo_in_ready;
  wire track_ok;

  assign track_ok = (pwr_d == `DAR_PWR_OP);
  assign result_ready_out = fifo_in_ready;

  always @(posedge clk_in) begin
    if (rst_in) begin
      sample_track_out <= 1'b0;
      conv_start_out <= 1'b0;
    end else begin
      conv_start_out <= 1'b0;
      if (strobe_rise && track_ok) begin
        sample_track_out <= 1'b1;
      end else if (strobe_fall && sample_track_out) begin
        sample_track_out <= 1'b0;
        conv_start_out <= fifo_in_ready;
      end else if (!track_ok) begin
        sample_track_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Result buffer
  // ----------------------------------------
  wire fifo_out_valid;
  wire [`DAR_WORD_W-1:0] fifo_out_data;
  reg fifo_pop;

  dar_fifo #(
    .WIDTH(`DAR_WORD_W),
    .DEPTH(`DAR_FIFO_DEPTH),
    .AW(`DAR_FIFO_AW),
    .CW(`DAR_FIFO_CW)
  ) u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_valid_in(result_valid_in),
    .in_data_in({result_one_in, result_two_in}),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_out_data),
    .out_ready_in(fifo_pop)
  );

  // ----------------------------------------
  // Serial shifter
  // ----------------------------------------
  reg [`DAR_RES_W-1:0] sh_one_q;
  reg [`DAR_RES_W-1:0] sh_two_q;
  reg [`DAR_BITCNT_W-1:0] bits_left_q;
  wire [`DAR_RES_W-1:0] word_one;
  wire [`DAR_RES_W-1:0] word_two;
  reg bit_one;
  reg bit_two;

  assign word_one = fifo_out_data[`DAR_WORD_W-1:`DAR_RES_W];
  assign word_two = fifo_out_data[`DAR_RES_W-1:0];

  always @* begin
    fifo_pop = 1'b0;
    bit_one = 1'b0;
    bit_two = 1'b0;
    if (sck_fall) begin
      if (bits_left_q == `DAR_BITS_NONE) begin
        fifo_pop = fifo_out_valid;
        // Empty buffer shifts out zeros
        bit_one = fifo_out_valid && word_one[`DAR_RES_MSB];
        bit_two = fifo_out_valid && word_two[`DAR_RES_MSB];
      end else begin
        bit_one = sh_one_q[`DAR_RES_MSB];
        bit_two = sh_two_q[`DAR_RES_MSB];
      end
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      sh_one_q <= {`DAR_RES_W{1'b0}};
      sh_two_q <= {`DAR_RES_W{1'b0}};
      bits_left_q <= `DAR_BITS_NONE;
      channel_one_serial_out_p_out <= 1'b0;
      channel_two_serial_out_p_out <= 1'b0;
    end else if (sck_fall) begin
      channel_one_serial_out_p_out <= bit_one;
      channel_two_serial_out_p_out <= bit_two;
      if (bits_left_q == `DAR_BITS_NONE) begin
        if (fifo_out_valid) begin
          sh_one_q <= {word_one[`DAR_RES_MSB-1:0], 1'b0};
          sh_two_q <= {word_two[`DAR_RES_MSB-1:0], 1'b0};
          bits_left_q <= `DAR_BITS_LAST;
        end
      end else begin
        sh_one_q <= {sh_one_q[`DAR_RES_MSB-1:0], 1'b0};
        sh_two_q <= {sh_two_q[`DAR_RES_MSB-1:0], 1'b0};
        bits_left_q <= bits_left_q - `DAR_BITCNT_W'h01;
      end
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // Echo clock registered in step with data so both see equal delay
  always @(posedge clk_in) begin
    if (rst_in) begin
      echoed_shift_clock_p_out <= 1'b0;
      echoed_shift_clock_n_out <= 1'b0;
      channel_one_serial_out_n_out <= 1'b0;
      channel_two_serial_out_n_out <= 1'b0;
      neg_pins_oe_out <= 1'b0;
      echo_pos_oe_out <= 1'b0;
    end else begin
      echoed_shift_clock_p_out <= sck_lvl_d && !echo_pos_off;
      echo_pos_oe_out <= !echo_pos_off;
      neg_pins_oe_out <= lvds_mode;
      if (lvds_mode) begin
        echoed_shift_clock_n_out <= !sck_lvl_d;
        channel_one_serial_out_n_out <= sck_fall ? !bit_one
                                                 : !channel_one_serial_out_p_out;
        channel_two_serial_out_n_out <= sck_fall ? !bit_two
                                                 : !channel_two_serial_out_p_out;
      end else begin
        echoed_shift_clock_n_out <= 1'b0;
        channel_one_serial_out_n_out <= 1'b0;
        channel_two_serial_out_n_out <= 1'b0;
      end
    end
  end

endmodule // dar_readout

`default_nettype wire

// ---- test/dar_readout_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dar_consts.vh"
// ----------------------------------------
// Readout pin checks
// ----------------------------------------
module dar_readout_asserts (
  // Clock, reset, mode pins
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic lvds_select_in,
  input wire logic echo_neg_tied_in,
  // Lanes and enables
  input wire logic channel_one_serial_out_p_out,
  input wire logic channel_one_serial_out_n_out,
  input wire logic channel_two_serial_out_n_out,
  input wire logic echoed_shift_clock_p_out,
  input wire logic echoed_shift_clock_n_out,
  input wire logic neg_pins_oe_out,
  input wire logic echo_pos_oe_out,
  // Core side
  input wire logic sample_track_out,
  input wire logic conv_start_out,
  input wire logic [`DAR_PWR_W-1:0] power_state_out,
  input wire logic result_ready_out
);
  logic [1:0] ps;
  logic c1p, ekp, ekn;
  assign ps = power_state_out;
  assign c1p = channel_one_serial_out_p_out;
  assign ekp = echoed_shift_clock_p_out;
  assign ekn = echoed_shift_clock_n_out;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  conv_pulse_a: assert property (conv_start_out |=> !conv_start_out)
    else $error("conv start too long");
  conv_hold_a: assert property ($fell(sample_track_out) && result_ready_out |-> conv_start_out)
    else $error("hold without conversion");
  track_op_a: assert property (sample_track_out |-> ps == `DAR_PWR_OP)
    else $error("tracking outside op");
  neg_low_a: assert property (!neg_pins_oe_out |-> !(channel_one_serial_out_n_out ||
    channel_two_serial_out_n_out || ekn)) else $error("negative pin not low");
  diff_pair_a: assert property (neg_pins_oe_out |-> channel_one_serial_out_n_out == !c1p
    && ekn == !ekp) else $error("pair not complementary");
  mode_pin_a: assert property (lvds_select_in [*8] |-> neg_pins_oe_out)
    else $error("differential mode not taken");
  echo_tie_a: assert property ((echo_neg_tied_in && !lvds_select_in) [*8] |->
    !echo_pos_oe_out && !ekp) else $error("echo not disabled");
  echo_skew_a: assert property (echo_pos_oe_out && $changed(c1p) |-> $fell(ekp))
    else $error("data moved off echo fall");
  nap_step_a: assert property ($past(ps) == `DAR_PWR_OP && ps != `DAR_PWR_OP |->
    ps == `DAR_PWR_NAP) else $error("op left to wrong state");
  sleep_exit_a: assert property ($past(ps) == `DAR_PWR_SLEEP |-> ps != `DAR_PWR_NAP)
    else $error("sleep left to nap");
  cover property (conv_start_out);
  cover property (ps == `DAR_PWR_SLEEP && neg_pins_oe_out);
  cover property (!result_ready_out);
endmodule // dar_readout_asserts

bind dar_readout dar_readout_asserts u_chk (
  .clk_in, .rst_in, .lvds_select_in, .echo_neg_tied_in,
  .channel_one_serial_out_p_out, .channel_one_serial_out_n_out,
  .channel_two_serial_out_n_out, .echoed_shift_clock_p_out,
  .echoed_shift_clock_n_out, .neg_pins_oe_out, .echo_pos_oe_out,
  .sample_track_out, .conv_start_out, .power_state_out, .result_ready_out
);
`default_nettype wire

// ---- test/dar_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Host stand-in
// ----------------------------------------
module dar_host_model (
  // Clock and mode
  input wire logic clk_in,
  input wire logic lvds_in,
  // Lanes from device
  input wire logic lane_one_in,
  input wire logic lane_two_in,
  // Host pins
  output logic strobe_out,
  output logic sck_p_out,
  output wire logic sck_n_out
);
  // Single-ended: negative pin rests on its pull-down
  assign sck_n_out = lvds_in ? !sck_p_out : 1'b0;
  initial begin
    strobe_out = 1'b0;
    sck_p_out = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // Clock left static between reads
  task automatic pulse();
    strobe_out = 1'b1;
    hold(8);
    strobe_out = 1'b0;
    hold(16);
  endtask
  // Each fall shifts a bit; taken late in the low half, clock idles low
  // Link clock scaled down: synchronised pins need two samples a level
  task automatic read(output logic [31:0] w);
    for (int i = 15; i >= 0; i--) begin
      sck_p_out = 1'b1;
      hold(8);
      sck_p_out = 1'b0;
      hold(8);
      w[i+16] = lane_one_in;
      w[i] = lane_two_in;
    end
  endtask
endmodule // dar_host_model
`default_nettype wire

// ---- test/tb_dual_adc_serial_readout_power_modes.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dar_consts.vh"
// ----------------------------------------
// Readout and power mode bench
// ----------------------------------------
module tb_dual_adc_serial_readout_power_modes;
  logic clk_in;
  logic rst_in;
  logic lvds, tie, rv, pend;
  logic [15:0] r1, r2;
  logic strobe, sckp, sckn, c1p, c1n, c2p, c2n, ekp, ekn, noe, eoe, trk, conv, rdy;
  logic [1:0] ps;
  logic [31:0] w;
  logic [31:0] q[$];
  logic [3:0] rows [4] = '{4'h1, 4'h4, 4'hb, 4'hf};
  int n_fail = 0, n_compared = 0;
  always #2.5 clk_in = !clk_in;
  dar_readout u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .convert_strobe_in(strobe),
    .sck_p_in(sckp), .sck_n_in(sckn), .lvds_select_in(lvds), .echo_neg_tied_in(tie),
    .channel_one_serial_out_p_out(c1p), .channel_one_serial_out_n_out(c1n),
    .channel_two_serial_out_p_out(c2p), .channel_two_serial_out_n_out(c2n),
    .echoed_shift_clock_p_out(ekp), .echoed_shift_clock_n_out(ekn),
    .neg_pins_oe_out(noe), .echo_pos_oe_out(eoe), .sample_track_out(trk),
    .conv_start_out(conv), .power_state_out(ps), .result_valid_in(rv),
    .result_one_in(r1), .result_two_in(r2), .result_ready_out(rdy)
  );
  dar_host_model u_host (.clk_in(clk_in), .lvds_in(lvds), .lane_one_in(c1p),
    .lane_two_in(c2p), .strobe_out(strobe), .sck_p_out(sckp), .sck_n_out(sckn));
  // Core stand-in: one result per conversion start
  always @(posedge clk_in) begin
    if (rst_in) begin
      pend <= 1'b0;
    end else begin
      if (conv) pend <= 1'b1;
      if (rv && rdy) begin
        q.push_back({r1, r2});
        pend <= 1'b0;
      end
    end
  end
  always @(negedge clk_in) begin
    if (rst_in) begin
      rv <= 1'b0;
      r1 <= 16'h8001;
      r2 <= 16'h7ffe;
    end else begin
      if (rv && !pend) begin
        r1 <= r1 + 16'h1111;
        r2 <= r2 ^ 16'h0ff0;
      end
      rv <= pend;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic rd();
    logic [31:0] e;
    e = q.size() ? q.pop_front() : 32'h0;
    u_host.read(w);
    check(w, e);
  endtask
  task automatic pl(input int n, input logic [1:0] e);
    repeat (n) u_host.pulse();
    check({30'h0, ps}, {30'h0, e});
  endtask
  initial begin
    clk_in = 1'b0;
    rst_in = 1'b1;
    {lvds, tie} = 2'h0;
    repeat (6) @(negedge clk_in);
    rst_in = 1'b0;
    check({28'h0, ps, trk, conv}, 32'h0);
    u_host.hold(40); // Scaled settle wait
    for (int i = 0; i < 4; i++) begin
      {lvds, tie} = rows[i][3:2];
      u_host.hold(12);
      check({30'h0, noe, eoe}, {30'h0, rows[i][1:0]});
      u_host.pulse();
      rd();
      $display("row %0d done", i);
    end
    {lvds, tie} = 2'h0;
    u_host.hold(12);
    pl(2, `DAR_PWR_NAP);
    rd();
    pl(0, `DAR_PWR_OP);
    pl(1, `DAR_PWR_OP);
    rd();
    pl(1, `DAR_PWR_OP);
    pl(1, `DAR_PWR_NAP);
    pl(2, `DAR_PWR_SLEEP);
    rd();
    pl(0, `DAR_PWR_OP);
    u_host.hold(40); // Scaled recharge wait
    pl(4, `DAR_PWR_SLEEP);
    pl(1, `DAR_PWR_OP);
    pl(1, `DAR_PWR_NAP);
    lvds = 1'b1;
    u_host.hold(12);
    rd();
    pl(4, `DAR_PWR_SLEEP);
    rd();
    pl(0, `DAR_PWR_SLEEP);
    pl(1, `DAR_PWR_OP);
    $display("power sequence done");
    // Fill until refused, then drain past empty
    lvds = 1'b0;
    u_host.hold(12);
    for (int i = 0; i < 64 && rdy; i++) u_host.pulse();
    check({31'h0, rdy}, 32'h0);
    check(q.size(), 32'h8);
    while (q.size() > 0) rd();
    rd();
    $display("buffer done");
    rst_in = 1'b1;
    u_host.hold(6);
    check({28'h0, ps, conv, rdy}, 32'h0);
    rst_in = 1'b0;
    u_host.hold(2);
    check({31'h0, rdy}, 32'h1);
    $display("reset done");
    final_report();
  end
  initial begin
    #200000;
    n_fail++;
    final_report();
  end
endmodule // tb_dual_adc_serial_readout_power_modes
`default_nettype wire
